// ### verilog/mste_engine.sv
// Interrupt-triggered single-item transfer engine
`timescale 1ns/1ps
`include "mste_regs.svh"
// How it works
// RULE1 - Buffer-in-channel type moves item either direction
// RULE2 - One 8- or 16-bit item per service
// RULE3 - Buffer address is pointer minus scaled count minus one
// RULE4 - Channel buffer stays in selected RAM page
// RULE5 - Register chosen by channel's 8-bit pointer
// RULE6 - Decrement count; at zero end and signal
// RULE7 - Mode byte read first, dispatch by type
// RULE8 - Pointer type moves item between memory, register
// RULE9 - Pointer advances by one or two
// RULE10 - Pointer and dual types use 16-bit count
// RULE11 - Pointer buffer may sit anywhere in space
// RULE12 - Channels located in RAM page by pointer
// RULE13 - Software keeps pointer bits 20-23 zero
// RULE14 - Dual type writes timer and data registers
// RULE15 - Timer pointer kept or stepped with data
// RULE16 - Data pointer steps by one each transfer
// RULE17 - Optional add of timer data to compare
// RULE18 - Timer write first, then data register write
// RULE19 - Ring counter wraps pointer and reloads
// RULE20 - Timer and data registers by 8-bit pointers
// RULE21 - Software presets ring counter to modulo length
// RULE22 - Suppress bit decides end interrupt or not
// RULE23 - One item per request, channel saved first
module mste_engine (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              rst_n,
  // Register port
  input  wire logic [7:0]        regAddr,
  input  wire logic [31:0]       regWdata,
  input  wire logic              regWr,
  input  wire logic              regRd,
  output logic [31:0]            regRdata,
  // Service request
  input  mste_pkg::mste_req_t    req,
  output logic                   reqReady,
  // Memory and register access
  output mste_pkg::mste_bus_t    busReq,
  input  wire logic [7:0]        memRdata,
  input  wire logic [7:0]        sfrRdata,
  // Completion
  output logic                   ismClr,
  output logic                   flagClr,
  output logic                   vecIrq,
  output logic                   otherReq,
  output logic [7:0]             otherOfs
);
  import mste_pkg::*;

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  mste_state_t stQ, stD;
  mste_type_t  typ;
  mste_bus_t   busD;
  logic [3:0]  idxQ, idxD, chLen;
  logic [1:0]  stepQ, stepD, nextStep, ctrlQ;
  logic [7:0]  modeQ, cptrQ, cofsQ, aOfs;
  logic [7:0]  chB [12];
  logic [11:0] pageQ, winPage;
  logic [15:0] opQ, cmpQ, sumV, transfer_count, mscN, itemsQ;
  logic [19:0] ptr1, ptr2, ptr1N, ptr2N, ptr2Inc;
  logic [19:0] tStep, memA, sfrA, dsfrA, gBase, sBase;
  logic [7:0]  rcN, rcNew, gByte;
  logic        accept, word, dir, vsup, keepT, add, ring, wrap;
  logic        gSfr, gCmp, sEn, sSfr, two, lastStep, readyD;
  logic        tWrQ;

  assign typ   = mste_type_t'(modeQ[`MSTE_M_TYPE]);
  assign word  = modeQ[`MSTE_M_WORD];
  assign dir   = modeQ[`MSTE_M_DIR];
  assign vsup  = modeQ[`MSTE_M_VSUP];
  assign keepT = modeQ[`MSTE_M_KEEPT];
  assign add   = modeQ[`MSTE_M_ADD];
  assign ring  = modeQ[`MSTE_M_RING];

  // Enable is seen one cycle late: a request in flight finishes
  assign accept  = req.valid && reqReady;
  assign winPage = ctrlQ[`MSTE_CTRL_WIN] ? `MSTE_PAGE_HI
                                         : `MSTE_PAGE_LO;

  // ---------------------------------------------------------------
  // Channel fields
  // ---------------------------------------------------------------
  // Upper nibble of the top pointer byte is ignored here
  assign ptr1 = {chB[3][3:0], chB[4], chB[5]}; // RULE13
  assign ptr2 = {chB[7][3:0], chB[8], chB[9]};
  assign transfer_count  = (typ == T_REGBUF) ? {8'h00, chB[0]}
                                  : {chB[0], chB[1]}; // RULE10
  assign mscN = transfer_count - 16'h0001; // RULE6
  assign aOfs = word ? cptrQ - {chB[0][6:0], 1'b0} - 8'h01
                     : cptrQ - chB[0] - 8'h01; // RULE3
  assign memA = (typ == T_REGBUF) ? {pageQ, aOfs} : ptr1; // RULE4 RULE11
  assign sfrA = {12'h000, (typ == T_REGBUF) ? chB[1]
                                            : chB[2]}; // RULE5 RULE20
  assign dsfrA = {12'h000, chB[6]}; // RULE20
  assign tStep = word ? 20'h00002 : 20'h00001;

  always_comb begin
    unique case (typ)
      T_REGBUF: chLen = `MSTE_LEN_A;
      T_PTRBUF: chLen = `MSTE_LEN_B;
      T_DUAL:   chLen = ring ? `MSTE_LEN_CR : `MSTE_LEN_C;
      T_OTHER:  chLen = `MSTE_LEN_A;
    endcase
  end

  // ---------------------------------------------------------------
  // Pointer and counter updates
  // ---------------------------------------------------------------
  always_comb begin
    if (typ == T_PTRBUF) begin
      ptr1N = ptr1 + tStep; // RULE9
    end else if (keepT) begin
      ptr1N = ptr1; // RULE15
    end else begin
      ptr1N = dir ? ptr1 - tStep : ptr1 + tStep; // RULE15
    end
  end

  assign ptr2Inc = dir ? ptr2 - 20'h00001
                       : ptr2 + 20'h00001; // RULE16
  assign rcN   = chB[11] - 8'h01; // RULE19
  assign wrap  = ring && (rcN == 8'h00); // RULE19
  assign rcNew = wrap ? chB[10] : rcN; // RULE19
  // Decrementing pointer wraps upward, incrementing one downward
  assign ptr2N = !wrap ? ptr2Inc
               : dir ? ptr2Inc + {12'h000, chB[10]}
                     : ptr2Inc - {12'h000, chB[10]}; // RULE19

  // ---------------------------------------------------------------
  // Transfer plan for the current step
  // ---------------------------------------------------------------
  always_comb begin
    gSfr = 1'b0;
    gCmp = 1'b0;
    sEn = 1'b0;
    sSfr = 1'b1;
    two = 1'b0;
    lastStep = 1'b0;
    gBase = memA;
    sBase = sfrA;
    unique case (typ)
      T_REGBUF, T_PTRBUF: begin
        gSfr = dir; // RULE1 RULE8
        gBase = dir ? sfrA : memA;
        sSfr = !dir;
        sBase = dir ? memA : sfrA;
        two = word; // RULE2
        sEn = 1'b1;
        lastStep = 1'b1;
      end
      T_DUAL: begin
        two = word;
        unique case (stepQ)
          2'h0: begin
            gBase = ptr1; // RULE14
            sEn = !add; // RULE17
          end
          2'h1: begin
            gSfr = 1'b1; // RULE17
            gCmp = 1'b1;
            gBase = sfrA;
            sEn = 1'b1;
          end
          default: begin
            gBase = ptr2; // RULE18
            two = 1'b0;
            sBase = dsfrA;
            sEn = 1'b1;
            lastStep = 1'b1;
          end
        endcase
      end
      T_OTHER: lastStep = 1'b1;
    endcase
  end

  // Compare read is only needed when adding
  assign nextStep = (stepQ == 2'h0 && !add) ? 2'h2
                                            : stepQ + 2'h1;
  assign sumV = (add && stepQ == 2'h1) ? opQ + cmpQ : opQ; // RULE17
  assign gByte = gSfr ? sfrRdata : memRdata;

  function automatic logic [19:0] byteAddr(input logic isSfr,
                                           input logic [19:0] base,
                                           input logic hi);
    byteAddr = isSfr ? {12'h000, base[7:0] + {7'h00, hi}}
                     : base + {19'h00000, hi};
  endfunction : byteAddr

  // ---------------------------------------------------------------
  // Sequencer
  // ---------------------------------------------------------------
  always_comb begin
    stD = stQ;
    idxD = idxQ;
    stepD = stepQ;
    busD = '0;
    unique case (stQ)
      ST_IDLE: if (accept) begin
        busD.valid = 1'b1; // RULE7
        busD.addr = {winPage, req.ofs}; // RULE12
        stD = ST_MWT;
      end
      ST_MWT: stD = ST_MCAP;
      ST_MCAP: begin
        busD.valid = 1'b1;
        busD.addr = {pageQ, cofsQ + 8'h01};
        stD = ST_PWT;
      end
      ST_PWT: stD = ST_PCAP;
      ST_PCAP: begin
        idxD = 4'h0;
        stepD = 2'h0;
        stD = (typ == T_OTHER) ? ST_FIN : ST_CHRD; // RULE7
      end
      ST_CHRD: begin
        busD.valid = 1'b1;
        busD.addr = {pageQ, cptrQ - {4'h0, idxQ}}; // RULE12
        stD = ST_CHWT;
      end
      ST_CHWT: stD = ST_CHCAP;
      ST_CHCAP: begin
        idxD = (idxQ == chLen - 4'h1) ? 4'h0 : idxQ + 4'h1;
        stD = (idxQ == chLen - 4'h1) ? ST_GRD : ST_CHRD;
      end
      ST_GRD: begin
        busD.valid = 1'b1;
        busD.toSfr = gSfr;
        busD.addr = byteAddr(gSfr, gBase, idxQ[0]);
        stD = ST_GWT;
      end
      ST_GWT: stD = ST_GCAP;
      ST_GCAP: begin
        idxD = 4'h0;
        if (two && !idxQ[0]) begin
          idxD = 4'h1;
          stD = ST_GRD;
        end else if (sEn) begin
          stD = ST_SWR;
        end else begin
          stepD = nextStep;
          stD = ST_GRD;
        end
      end
      ST_SWR: begin
        busD.valid = 1'b1;
        busD.write = 1'b1;
        busD.toSfr = sSfr;
        busD.addr = byteAddr(sSfr, sBase, idxQ[0]);
        busD.wdata = idxQ[0] ? sumV[15:8] : sumV[7:0];
        idxD = 4'h0;
        if (two && !idxQ[0]) begin
          idxD = 4'h1;
        end else if (lastStep) begin
          stD = ST_UPD; // RULE23
        end else begin
          stepD = nextStep; // RULE18
          stD = ST_GRD;
        end
      end
      ST_UPD: begin
        idxD = 4'h0;
        stD = ST_WB;
      end
      ST_WB: begin
        busD.valid = 1'b1;
        busD.write = 1'b1;
        busD.addr = {pageQ, cptrQ - {4'h0, idxQ}};
        busD.wdata = chB[idxQ];
        idxD = idxQ + 4'h1;
        stD = (idxQ == chLen - 4'h1) ? ST_FIN : ST_WB; // RULE23
      end
      ST_FIN: stD = ST_IDLE;
      default: stD = ST_IDLE;
    endcase
  end

  // Ready only returns once the channel is written back or, for the other type, once the request is handed on
  assign readyD = (stD == ST_IDLE) && ctrlQ[`MSTE_CTRL_EN]; // RULE23

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stQ <= ST_IDLE;
      idxQ <= 4'h0;
      stepQ <= 2'h0;
      busReq <= '0;
      reqReady <= 1'b0;
    end else begin
      stQ <= stD;
      idxQ <= idxD;
      stepQ <= stepD;
      busReq <= busD;
      reqReady <= readyD;
    end
  end

  // ---------------------------------------------------------------
  // Control word and item capture
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      modeQ <= 8'h00;
      cptrQ <= 8'h00;
      cofsQ <= 8'h00;
      pageQ <= `MSTE_PAGE_LO;
      opQ <= 16'h0000;
      cmpQ <= 16'h0000;
    end else begin
      if (accept) begin
        cofsQ <= req.ofs;
        pageQ <= winPage; // RULE4
      end
      if (stQ == ST_MCAP) modeQ <= memRdata; // RULE7
      if (stQ == ST_PCAP) cptrQ <= memRdata;
      if (stQ == ST_GCAP && gCmp && idxQ[0]) cmpQ[15:8] <= gByte;
      if (stQ == ST_GCAP && gCmp && !idxQ[0]) cmpQ[7:0] <= gByte;
      if (stQ == ST_GCAP && !gCmp && idxQ[0]) opQ[15:8] <= gByte;
      if (stQ == ST_GCAP && !gCmp && !idxQ[0]) opQ[7:0] <= gByte;
    end
  end

  // ---------------------------------------------------------------
  // Channel image
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < 12; i++) chB[i] <= 8'h00;
    end else if (stQ == ST_CHCAP) begin
      chB[idxQ] <= memRdata;
    end else if (stQ == ST_UPD) begin
      if (typ == T_REGBUF) begin
        chB[0] <= mscN[7:0]; // RULE6
      end else begin
        chB[0] <= mscN[15:8]; // RULE10
        chB[1] <= mscN[7:0];
        chB[3] <= {4'h0, ptr1N[19:16]};
        chB[4] <= ptr1N[15:8];
        chB[5] <= ptr1N[7:0];
      end
      if (typ == T_DUAL) begin
        chB[7] <= {4'h0, ptr2N[19:16]}; // RULE16
        chB[8] <= ptr2N[15:8];
        chB[9] <= ptr2N[7:0];
        if (ring) chB[11] <= rcNew; // RULE19
      end
    end
  end

  // ---------------------------------------------------------------
  // Completion signalling
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ismClr <= 1'b0;
      flagClr <= 1'b0;
      vecIrq <= 1'b0;
      otherReq <= 1'b0;
      otherOfs <= 8'h00;
    end else begin
      ismClr <= 1'b0;
      flagClr <= 1'b0;
      vecIrq <= 1'b0;
      otherReq <= 1'b0;
      if (stQ == ST_FIN && typ == T_OTHER) begin
        otherReq <= 1'b1; // RULE7
        otherOfs <= cofsQ;
      end else if (stQ == ST_FIN && transfer_count == 16'h0000) begin
        ismClr <= 1'b1; // RULE6
        flagClr <= vsup; // RULE22
        vecIrq <= !vsup; // RULE22
      end
    end
  end

  // ---------------------------------------------------------------
  // Register port
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrlQ <= `MSTE_CTRL_RST;
      itemsQ <= 16'h0000;
      regRdata <= 32'h00000000;
    end else begin
      if (regWr && regAddr == `MSTE_REG_CTRL) ctrlQ <= regWdata[1:0];
      if (stQ == ST_FIN && typ != T_OTHER) itemsQ <= itemsQ + 16'h0001;
      regRdata <= 32'h00000000;
      if (regRd) begin
        unique case (regAddr)
          `MSTE_REG_CTRL:  regRdata <= {30'h0, ctrlQ};
          `MSTE_REG_STAT:  regRdata <= {25'h0, stQ, typ,
                                        stQ != ST_IDLE};
          `MSTE_REG_ITEMS: regRdata <= {16'h0, itemsQ};
          default:         regRdata <= 32'h00000000;
        endcase
      end
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) tWrQ <= 1'b0;
    else if (accept) tWrQ <= 1'b0;
    else if (stQ == ST_SWR && stepQ != 2'h2) tWrQ <= 1'b1;
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_ctrl_reads;
    busReq.valid && !busReq.write && !busReq.toSfr
    ##2 busReq.valid && !busReq.write
        && busReq.addr[7:0] == $past(req.ofs, 3) + 8'h01;
  endsequence

  a_mode_first: // RULE7 RULE12
    assert property (accept |=> s_ctrl_reads)
    else $error("control word not read first");
  a_busy_hold: // RULE23
    assert property (accept |=> !reqReady [*5])
    else $error("request taken while busy");
  a_bufa_addr: // RULE3 RULE4
    assert property (stQ == ST_GWT && typ == T_REGBUF && !dir
                     && !idxQ[0] |-> busReq.addr == {pageQ, aOfs})
    else $error("channel buffer address wrong");
  a_sfr_pick: // RULE5
    assert property (stQ == ST_GWT && typ != T_DUAL && dir
                     && !idxQ[0] |-> busReq.toSfr
                     && busReq.addr[7:0] == sfrA[7:0])
    else $error("wrong register selected");
  a_count_step: // RULE6 RULE10
    assert property (stQ == ST_UPD && typ != T_REGBUF
                     |=> transfer_count == $past(transfer_count) - 16'h0001)
    else $error("count not decremented");
  a_end_vector: // RULE6 RULE22
    assert property (stQ == ST_FIN && typ != T_OTHER
                     && transfer_count == 16'h0000 && !vsup
                     |=> vecIrq && ismClr && !flagClr)
    else $error("missing end interrupt");
  a_end_quiet: // RULE22
    assert property (stQ == ST_FIN && typ != T_OTHER
                     && transfer_count == 16'h0000 && vsup
                     |=> flagClr && ismClr && !vecIrq)
    else $error("interrupt not suppressed");
  a_mid_quiet: // RULE6
    assert property (stQ == ST_FIN && transfer_count != 16'h0000
                     |=> !ismClr && !vecIrq && !flagClr)
    else $error("early end signal");
  a_bptr_step: // RULE9 RULE11
    assert property (stQ == ST_UPD && typ == T_PTRBUF
                     |=> ptr1 == $past(ptr1) + tStep)
    else $error("buffer pointer step wrong");
  a_mpd_step: // RULE16
    assert property (stQ == ST_UPD && typ == T_DUAL && !ring
                     |=> ptr2 == ($past(dir) ? $past(ptr2) - 20'h1
                                            : $past(ptr2) + 20'h1))
    else $error("data pointer step wrong");
  a_ring_wrap: // RULE19
    assert property (stQ == ST_UPD && typ == T_DUAL && ring
                     && chB[11] == 8'h01 |=> chB[11] == $past(chB[10]))
    else $error("ring counter not reloaded");
  a_mpt_keep: // RULE15
    assert property (stQ == ST_UPD && typ == T_DUAL && keepT
                     |=> ptr1 == $past(ptr1))
    else $error("timer pointer moved");
  a_add_sum: // RULE17
    assert property (stQ == ST_SWR && typ == T_DUAL && stepQ == 2'h1
                     && !idxQ[0] |=> busReq.wdata
                     == $past(opQ[7:0]) + $past(cmpQ[7:0]))
    else $error("compare sum wrong");
  a_timer_first: // RULE18 RULE14
    assert property (stQ == ST_SWR && typ == T_DUAL
                     && stepQ == 2'h2 |-> tWrQ)
    else $error("data written before timer");

endmodule : mste_engine

// ### verilog/mste_regs.svh
// Offsets, mode bit positions, reset values and channel lengths
`ifndef MSTE_REGS_SVH
`define MSTE_REGS_SVH

// ---------------------------------------------------------------
// Register offsets and reset values
// ---------------------------------------------------------------
`define MSTE_REG_CTRL  8'h00
`define MSTE_REG_STAT  8'h04
`define MSTE_REG_ITEMS 8'h08
`define MSTE_CTRL_RST  2'h0
`define MSTE_CTRL_EN   0
`define MSTE_CTRL_WIN  1

// ---------------------------------------------------------------
// Internal RAM page (upper 12 address bits)
// ---------------------------------------------------------------
`define MSTE_PAGE_LO   12'h0fe
`define MSTE_PAGE_HI   12'hffe

// ---------------------------------------------------------------
// Mode byte layout
// ---------------------------------------------------------------
`define MSTE_M_TYPE    7:6
`define MSTE_M_WORD    0
`define MSTE_M_DIR     1
`define MSTE_M_VSUP    2
`define MSTE_M_KEEPT   3
`define MSTE_M_ADD     4
`define MSTE_M_RING    5

// ---------------------------------------------------------------
// Channel length in bytes per type
// ---------------------------------------------------------------
`define MSTE_LEN_A     4'h2
`define MSTE_LEN_B     4'h6
`define MSTE_LEN_C     4'ha
`define MSTE_LEN_CR    4'hc

`endif

// ### verilog/mste_pkg.sv
// Types shared by the transfer engine and its users
package mste_pkg;

  // ---------------------------------------------------------------
  // Channel types and sequencer states
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    T_OTHER  = 2'b00,
    T_REGBUF = 2'b01,
    T_PTRBUF = 2'b10,
    T_DUAL   = 2'b11
  } mste_type_t;

  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0000, ST_MWT  = 4'b0001, ST_MCAP = 4'b0010,
    ST_PWT   = 4'b0011, ST_PCAP = 4'b0100, ST_CHRD = 4'b0101,
    ST_CHWT  = 4'b0110, ST_CHCAP = 4'b0111, ST_GRD = 4'b1000,
    ST_GWT   = 4'b1001, ST_GCAP = 4'b1010, ST_SWR  = 4'b1011,
    ST_UPD   = 4'b1100, ST_WB   = 4'b1101, ST_FIN  = 4'b1110
  } mste_state_t;

  // ---------------------------------------------------------------
  // Carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic        valid;
    logic [7:0]  ofs;
  } mste_req_t;

  typedef struct packed {
    logic        valid;
    logic        write;
    logic        toSfr;
    logic [19:0] addr;
    logic [7:0]  wdata;
  } mste_bus_t;

endpackage : mste_pkg

// ### sim/mste_mem_model.sv
// Behavioural memory and peripheral register file facing the engine
`timescale 1ns/1ps
module mste_mem_model
  import mste_pkg::*;
(
  // Clock
  input  wire logic           clk,
  // Engine access
  input  mste_pkg::mste_bus_t busReq,
  output logic [7:0]          memRdata,
  output logic [7:0]          sfrRdata
);
  logic [7:0] mem  [int];
  logic [7:0] sfr  [int];
  logic [7:0] wlog [$];

  function automatic logic [7:0] look(input bit s, input int a);
    if (s)
      return sfr.exists(a) ? sfr[a] : 8'h00;
    return mem.exists(a) ? mem[a] : 8'h00;
  endfunction : look

  initial begin
    memRdata = 8'h00;
    sfrRdata = 8'h00;
  end

  // Read data stands one cycle, then toggles so stale data never matches
  always @(posedge clk) begin
    memRdata <= ~memRdata;
    sfrRdata <= ~sfrRdata;
    if (busReq.valid && busReq.write && busReq.toSfr) begin
      sfr[busReq.addr[7:0]] = busReq.wdata;
      wlog.push_back(busReq.addr[7:0]);
    end else if (busReq.valid && busReq.write)
      mem[busReq.addr] = busReq.wdata;
    else if (busReq.valid && busReq.toSfr)
      sfrRdata <= look(1'b1, busReq.addr[7:0]);
    else if (busReq.valid)
      memRdata <= look(1'b0, busReq.addr);
  end
endmodule : mste_mem_model

// ### sim/tb.sv
// Self-checking bench for the transfer engine
`timescale 1ns/1ps
module tb;
  import mste_pkg::*;
  typedef struct packed {
    logic [7:0]  mode;
    logic [15:0] cnt;
    logic [19:0] bufA;
    logic        hi;
    logic [2:0]  ends;
  } mste_row_t;
  logic clk, rst_n, regWr, regRd, reqReady, ismClr, flagClr, vecIrq;
  logic otherReq;
  logic [7:0]  regAddr, memRdata, sfrRdata, otherOfs, oOfs;
  logic [31:0] regWdata, regRdata;
  mste_req_t   req;
  mste_bus_t   busReq;
  int failures, checked, cycles, nIsm, nFlag, nVec, nOther;
  // Mode, count, buffer, window, {ism, flag, vec}
  mste_row_t rows [6] = '{
    '{8'h40, 16'h0001, 20'h0fe3e, 1'b0, 3'b101},
    '{8'h47, 16'h0002, 20'h0fe3b, 1'b0, 3'b000},
    '{8'h46, 16'h0001, 20'hffe3e, 1'b1, 3'b110},
    '{8'h80, 16'h0001, 20'habcde, 1'b0, 3'b101},
    '{8'h83, 16'h0100, 20'h1fffe, 1'b0, 3'b000},
    '{8'h86, 16'h0001, 20'h00010, 1'b1, 3'b110}};
  logic [7:0] ch [12] = '{8'h00, 8'h03, 8'h52, 8'h02, 8'h00, 8'h00,
                          8'h98, 8'h03, 8'h00, 8'h00, 8'h04, 8'h01};

  mste_engine i_dut (.clk(clk), .rst_n(rst_n), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
    .regRdata(regRdata), .req(req), .reqReady(reqReady),
    .busReq(busReq), .memRdata(memRdata), .sfrRdata(sfrRdata),
    .ismClr(ismClr), .flagClr(flagClr), .vecIrq(vecIrq),
    .otherReq(otherReq), .otherOfs(otherOfs));
  mste_mem_model i_mem (.clk(clk), .busReq(busReq),
    .memRdata(memRdata), .sfrRdata(sfrRdata));

  always #12.5 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    nIsm += int'(ismClr === 1'b1);
    nFlag += int'(flagClr === 1'b1);
    nVec += int'(vecIrq === 1'b1);
    if (otherReq === 1'b1) begin
      nOther++;
      oOfs = otherOfs;
    end
    if (cycles == 20000) begin
      failures++;
      results();
    end
  end

  task chk(input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      failures++;
      $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge clk);
    regWr <= 1'b0;
  endtask : wr
  task rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge clk);
    regRd <= 1'b0;
    #1 d = regRdata;
  endtask : rd
  // Bounded wait: a lost request must not hang the run
  task automatic svc(input logic [7:0] o);
    int n;
    n = 0;
    @(posedge clk);
    req <= '{valid: 1'b1, ofs: o};
    @(posedge clk);
    req <= '0;
    do begin
      @(posedge clk);
      #1 n++;
    end while (reqReady !== 1'b1 && n < 500);
    @(posedge clk);
    #1;
  endtask : svc
  task results;
    $display("checks=%0d failures=%0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : results

  initial begin
    logic [31:0] d;
    logic [19:0] pg;
    mste_row_t r;
    logic w;
    logic [7:0] nb;
    int s0;
    {clk, rst_n, regWr, regRd, regAddr, regWdata, req} = '0;
    repeat (6) @(posedge clk);
    #1 chk({reqReady, ismClr, flagClr, vecIrq, otherReq}, 0);
    chk(busReq, 0);
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    i_mem.mem[20'h0fe26] = 8'h00;
    svc(8'h26);
    chk(nOther + int'(reqReady), 0);
    $display("test reset done");
    foreach (rows[k]) begin
      r = rows[k];
      pg = r.hi ? 20'hffe00 : 20'h0fe00;
      w = r.mode[0];
      wr(8'h00, {30'h0, r.hi, 1'b1});
      i_mem.mem[pg + 20'h26] = r.mode;
      i_mem.mem[pg + 20'h27] = 8'h40;
      i_mem.sfr[8'h70] = 8'hc3;
      i_mem.sfr[8'h71] = 8'h3c;
      i_mem.mem[r.bufA] = 8'h5a;
      i_mem.mem[r.bufA + 20'h1] = 8'ha6;
      i_mem.mem[pg + 20'h40] = r.mode[7] ? r.cnt[15:8] : r.cnt[7:0];
      i_mem.mem[pg + 20'h3f] = r.mode[7] ? r.cnt[7:0] : 8'h70;
      // Short channels keep their buffer where the long ones hold fields
      if (r.mode[7]) begin
        i_mem.mem[pg + 20'h3e] = 8'h70;
        i_mem.mem[pg + 20'h3d] = {4'h0, r.bufA[19:16]};
        i_mem.mem[pg + 20'h3c] = r.bufA[15:8];
        i_mem.mem[pg + 20'h3b] = r.bufA[7:0];
      end
      nb = i_mem.mem[r.bufA + 20'h1];
      s0 = nIsm * 4 + nFlag * 2 + nVec;
      svc(8'h26);
      if (r.mode[1]) begin
        chk(i_mem.mem[r.bufA], 8'hc3);
        chk(i_mem.mem[r.bufA + 20'h1], w ? 8'h3c : nb);
      end else begin
        chk(i_mem.sfr[8'h70], 8'h5a);
        chk(i_mem.sfr[8'h71], w ? 8'ha6 : 8'h3c);
      end
      if (r.mode[7]) begin
        chk({i_mem.mem[pg + 20'h40], i_mem.mem[pg + 20'h3f]},
            r.cnt - 16'h1);
        chk({i_mem.mem[pg + 20'h3d], i_mem.mem[pg + 20'h3c],
             i_mem.mem[pg + 20'h3b]},
            {4'h0, r.bufA + (w ? 20'h2 : 20'h1)});
      end else
        chk(i_mem.mem[pg + 20'h40], r.cnt[7:0] - 8'h1);
      chk(nIsm * 4 + nFlag * 2 + nVec - s0, r.ends);
    end
    $display("test rows done");
    wr(8'h00, 32'h1);
    i_mem.mem[20'h0fe26] = 8'hf0;
    // Ring count preset short of the modulo length to force a wrap
    for (int i = 0; i < 12; i++)
      i_mem.mem[20'h0fe40 - i] = ch[i];
    i_mem.mem[20'h20000] = 8'h05;
    i_mem.mem[20'h30000] = 8'ha5;
    i_mem.sfr[8'h52] = 8'h10;
    i_mem.wlog.delete();
    s0 = nIsm + nFlag + nVec;
    svc(8'h26);
    chk(i_mem.sfr[8'h52], 8'h15);
    chk(i_mem.sfr[8'h98], 8'ha5);
    chk({i_mem.wlog[0], i_mem.wlog[1]}, 16'h5298);
    chk({i_mem.mem[20'h0fe3d], i_mem.mem[20'h0fe3c],
         i_mem.mem[20'h0fe3b]}, 24'h020001);
    chk({i_mem.mem[20'h0fe39], i_mem.mem[20'h0fe38],
         i_mem.mem[20'h0fe37]}, 24'h02fffd);
    chk(i_mem.mem[20'h0fe35], 8'h04);
    chk({i_mem.mem[20'h0fe40], i_mem.mem[20'h0fe3f]}, 16'h2);
    chk(nIsm + nFlag + nVec - s0, 0);
    // Word timer data, timer pointer held, data pointer counting down
    i_mem.mem[20'h0fe26] = 8'hcb;
    i_mem.mem[20'h20001] = 8'h77;
    i_mem.mem[20'h20002] = 8'h12;
    i_mem.mem[20'h2fffd] = 8'h3c;
    svc(8'h26);
    chk({i_mem.sfr[8'h53], i_mem.sfr[8'h52]}, 16'h1277);
    chk(i_mem.sfr[8'h98], 8'h3c);
    chk({i_mem.mem[20'h0fe3d], i_mem.mem[20'h0fe3c],
         i_mem.mem[20'h0fe3b]}, 24'h020001);
    chk({i_mem.mem[20'h0fe39], i_mem.mem[20'h0fe38],
         i_mem.mem[20'h0fe37]}, 24'h02fffc);
    $display("test dual done");
    rd(8'h08, d);
    chk(d, 32'h8);
    rd(8'h0c, d);
    chk(d, 32'h0);
    i_mem.mem[20'h0fe26] = 8'h00;
    svc(8'h26);
    chk({nOther, oOfs}, {32'h1, 8'h26});
    $display("test dispatch done");
    results();
  end
endmodule : tb
